// ### design/math_block_operator_unit.sv
`timescale 1ns/100ps
module math_block_operator_unit (
  input  wire logic                                          clock_i,
  input  wire logic                                          reset_n_i,
  input  wire logic                                          valid_i,
  input  wire math_op_pkg::data_type                         operand_a_i,
  input  wire logic [math_op_pkg::NUM_STAGES-1:0][math_op_pkg::DATA_W-1:0] operand_b_i,
  input  wire logic [math_op_pkg::NUM_STAGES-1:0][math_op_pkg::OP_W-1:0]   op_code_i,
  input  wire logic [math_op_pkg::NUM_STAGES-1:0]            b_used_i,
  output math_op_pkg::data_type                              result_o,
  output logic                                               result_valid_o,
  output logic                                               div_zero_o,
  output logic                                               saturated_o
);
  import math_op_pkg::*;

  typedef logic [NUM_STAGES-1:0][DATA_W-1:0] b_vec_type;
  typedef logic [NUM_STAGES-1:0][OP_W-1:0]   op_vec_type;
  typedef logic [NUM_STAGES-1:0]             use_vec_type;

  function automatic logic is_true(input data_type v);
    is_true = (v >= TRUE_THRESHOLD);
  endfunction

  function automatic data_type to_bool(input logic t);
    to_bool = t ? TRUE_VALUE : FALSE_VALUE;
  endfunction

  function automatic logic op_supported(input op_type op);
    op_supported = (op <= OP_MAX);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_n;

  reset_sync u_reset_sync (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .reset_n_o (rst_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // stage pipeline registers; each carries the configuration of later stages

  data_type    acc_q   [NUM_STAGES-1];
  logic        vld_q   [NUM_STAGES-1];
  logic        zero_q  [NUM_STAGES-1];
  logic        sat_q   [NUM_STAGES-1];
  b_vec_type   bvec_q  [NUM_STAGES-1];
  op_vec_type  opvec_q [NUM_STAGES-1];
  use_vec_type usevec_q[NUM_STAGES-1];

  data_type    st_a    [NUM_STAGES];
  logic        st_vld  [NUM_STAGES];
  logic        st_zero [NUM_STAGES];
  logic        st_sat  [NUM_STAGES];
  b_vec_type   st_bvec [NUM_STAGES];
  op_vec_type  st_opvec[NUM_STAGES];
  use_vec_type st_use  [NUM_STAGES];

  data_type    res_d   [NUM_STAGES];
  logic        zero_d  [NUM_STAGES];
  logic        sat_d   [NUM_STAGES];

  data_type    result_q;
  logic        result_valid_q;
  logic        div_zero_q;
  logic        saturated_q;

  genvar k;
  generate
    for (k = 0; k < NUM_STAGES; k++) begin : g_stage
      data_type    b;
      op_type      op;
      logic [16:0] sum;
      logic [31:0] prod;
      logic [31:0] prod_scaled;
      data_type    quot;
      logic        quot_zero;
      logic        quot_clamp;

      // only the first stage sees operand a from outside
      if (k == 0) begin : g_first
        assign st_a[k]     = operand_a_i;
        assign st_vld[k]   = valid_i;
        assign st_zero[k]  = 1'b0;
        assign st_sat[k]   = 1'b0;
        assign st_bvec[k]  = operand_b_i;
        assign st_opvec[k] = op_code_i;
        assign st_use[k]   = b_used_i;
      end else begin : g_chain
        assign st_a[k]     = acc_q[k-1];
        assign st_vld[k]   = vld_q[k-1];
        assign st_zero[k]  = zero_q[k-1];
        assign st_sat[k]   = sat_q[k-1];
        assign st_bvec[k]  = bvec_q[k-1];
        assign st_opvec[k] = opvec_q[k-1];
        assign st_use[k]   = usevec_q[k-1];
      end

      assign b           = st_bvec[k][k];
      assign op          = st_opvec[k][k];
      assign sum         = {1'b0, st_a[k]} + {1'b0, b};
      assign prod        = 32'(st_a[k]) * 32'(b);
      assign prod_scaled = prod / 32'(FULL_SCALE);

      quotient_unit u_quotient (
        .dividend_i (st_a[k]),
        .divisor_i  (b),
        .quotient_o (quot),
        .zero_div_o (quot_zero),
        .clamped_o  (quot_clamp)
      );

      always_comb begin
        res_d[k]  = st_a[k];
        zero_d[k] = 1'b0;
        sat_d[k]  = 1'b0;
        if (st_use[k][k] && op_supported(op)) begin
          unique case (op)
            OP_EQ:  res_d[k] = to_bool(st_a[k] == b);
            OP_NE:  res_d[k] = to_bool(st_a[k] != b);
            OP_GT:  res_d[k] = to_bool(st_a[k] > b);
            OP_GE:  res_d[k] = to_bool(st_a[k] >= b);
            OP_LT:  res_d[k] = to_bool(st_a[k] < b);
            OP_LE:  res_d[k] = to_bool(st_a[k] <= b);
            OP_OR:  res_d[k] = to_bool(is_true(st_a[k]) | is_true(b));
            OP_AND: res_d[k] = to_bool(is_true(st_a[k]) & is_true(b));
            OP_XOR: res_d[k] = to_bool(is_true(st_a[k]) ^ is_true(b));
            OP_ADD: begin
              if (sum > {1'b0, FULL_SCALE}) begin
                res_d[k] = FULL_SCALE;
                sat_d[k] = 1'b1;
              end else begin
                res_d[k] = sum[DATA_W-1:0];
              end
            end
            OP_SUB: begin
              if (st_a[k] < b) begin
                res_d[k] = ZERO_VALUE;
                sat_d[k] = 1'b1;
              end else begin
                res_d[k] = st_a[k] - b;
              end
            end
            OP_MUL: begin
              if (prod_scaled > 32'(FULL_SCALE)) begin
                res_d[k] = FULL_SCALE;
                sat_d[k] = 1'b1;
              end else begin
                res_d[k] = prod_scaled[DATA_W-1:0];
              end
            end
            OP_DIV: begin
              res_d[k]  = quot;
              zero_d[k] = quot_zero;
              sat_d[k]  = quot_clamp;
            end
            OP_MIN: res_d[k] = (st_a[k] <= b) ? st_a[k] : b;
            OP_MAX: res_d[k] = (st_a[k] >= b) ? st_a[k] : b;
            default: res_d[k] = st_a[k];
          endcase
        end
      end

      if (k < NUM_STAGES - 1) begin : g_reg
        always_ff @(posedge clock_i or negedge rst_n) begin
          if (!rst_n) begin
            acc_q[k]    <= RESULT_RESET;
            vld_q[k]    <= 1'b0;
            zero_q[k]   <= 1'b0;
            sat_q[k]    <= 1'b0;
            bvec_q[k]   <= '0;
            opvec_q[k]  <= '0;
            usevec_q[k] <= '0;
          end else begin
            acc_q[k]    <= res_d[k];
            vld_q[k]    <= st_vld[k];
            zero_q[k]   <= st_zero[k] | zero_d[k];
            sat_q[k]    <= st_sat[k] | sat_d[k];
            bvec_q[k]   <= st_bvec[k];
            opvec_q[k]  <= st_opvec[k];
            usevec_q[k] <= st_use[k];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // final stage result, held between samples

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      result_q    <= RESULT_RESET;
      div_zero_q  <= 1'b0;
      saturated_q <= 1'b0;
    end else if (st_vld[NUM_STAGES-1]) begin
      result_q    <= res_d[NUM_STAGES-1];
      div_zero_q  <= st_zero[NUM_STAGES-1] | zero_d[NUM_STAGES-1];
      saturated_q <= st_sat[NUM_STAGES-1] | sat_d[NUM_STAGES-1];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      result_valid_q <= 1'b0;
    end else begin
      result_valid_q <= st_vld[NUM_STAGES-1];
    end
  end

  assign result_o       = result_q;
  assign result_valid_o = result_valid_q;
  assign div_zero_o     = div_zero_q;
  assign saturated_o    = saturated_q;

endmodule

// ### design/math_op_pkg.sv
package math_op_pkg;

  localparam int unsigned DATA_W     = 16;
  localparam int unsigned OP_W       = 4;
  localparam int unsigned NUM_STAGES = 4;

  typedef logic [DATA_W-1:0] data_type;
  typedef logic [OP_W-1:0]   op_type;

  // percentage scale: one lsb is 0.01 %, full scale is 100.00 %
  localparam data_type FULL_SCALE     = 16'h2710;
  localparam data_type ZERO_VALUE     = 16'h0000;
  localparam data_type TRUE_THRESHOLD = 16'h0001;
  localparam data_type TRUE_VALUE     = 16'h0001;
  localparam data_type FALSE_VALUE    = 16'h0000;

  // operator codes
  localparam op_type OP_EQ  = 4'h0;
  localparam op_type OP_NE  = 4'h1;
  localparam op_type OP_GT  = 4'h2;
  localparam op_type OP_GE  = 4'h3;
  localparam op_type OP_LT  = 4'h4;
  localparam op_type OP_LE  = 4'h5;
  localparam op_type OP_OR  = 4'h6;
  localparam op_type OP_AND = 4'h7;
  localparam op_type OP_XOR = 4'h8;
  localparam op_type OP_ADD = 4'h9;
  localparam op_type OP_SUB = 4'ha;
  localparam op_type OP_MUL = 4'hb;
  localparam op_type OP_DIV = 4'hc;
  localparam op_type OP_MIN = 4'hd;
  localparam op_type OP_MAX = 4'he;

  // reset values of the result registers
  localparam data_type RESULT_RESET = 16'h0000;

endpackage

// ### design/quotient_unit.sv
`timescale 1ns/100ps
module quotient_unit (
  input  wire math_op_pkg::data_type dividend_i,
  input  wire math_op_pkg::data_type divisor_i,
  output math_op_pkg::data_type      quotient_o,
  output logic                       zero_div_o,
  output logic                       clamped_o
);
  import math_op_pkg::*;

  logic [31:0] scaled;
  logic [31:0] raw;

  // a / b expressed as a percentage of full scale
  assign scaled = 32'(dividend_i) * 32'(FULL_SCALE);
  assign raw    = (divisor_i == ZERO_VALUE) ? 32'h0000_0000 : scaled / 32'(divisor_i);

  always_comb begin
    zero_div_o = 1'b0;
    clamped_o  = 1'b0;
    quotient_o = raw[DATA_W-1:0];
    if (divisor_i == ZERO_VALUE) begin
      zero_div_o = 1'b1;
      quotient_o = FULL_SCALE;
    end else if (raw > 32'(FULL_SCALE)) begin
      clamped_o  = 1'b1;
      quotient_o = FULL_SCALE;
    end
  end

endmodule

// ### design/reset_sync.sv
`timescale 1ns/100ps
module reset_sync (
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  output logic      reset_n_o
);

  logic meta_q;
  logic held_q;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= 1'b0;
      held_q <= 1'b0;
    end else begin
      meta_q <= 1'b1;
      held_q <= meta_q;
    end
  end

  assign reset_n_o = held_q;

endmodule

// ### testbench/math_block_operator_unit_properties.sv
`timescale 1ns/100ps
module math_block_operator_unit_checker
  import math_op_pkg::*;
(
  input wire logic                                clock_i,
  input wire logic                                reset_n_i,
  input wire logic                                valid_i,
  input wire data_type                            operand_a_i,
  input wire logic [NUM_STAGES-1:0][DATA_W-1:0]   operand_b_i,
  input wire logic [NUM_STAGES-1:0][OP_W-1:0]     op_code_i,
  input wire logic [NUM_STAGES-1:0]               b_used_i,
  input wire data_type                            result_o,
  input wire logic                                result_valid_o,
  input wire logic                                div_zero_o,
  input wire logic                                saturated_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  // only stage 0 active
  wire logic one_st = valid_i && b_used_i == 4'h1;

  // result registers load at the third edge after the sample, seen one edge later
  chk_sample_latency: assert property (
    valid_i |-> ##4 result_valid_o) else $error("result pulse missing");
  chk_no_spurious: assert property (
    result_valid_o |-> $past(valid_i, 4)) else $error("result pulse without sample");
  chk_gt_true: assert property (
    one_st && op_code_i[0] == OP_GT && operand_a_i > operand_b_i[0]
    |-> ##4 result_o == TRUE_VALUE) else $error("greater than not true");
  chk_le_false: assert property (
    one_st && op_code_i[0] == OP_LE && operand_a_i > operand_b_i[0]
    |-> ##4 result_o == FALSE_VALUE) else $error("less or equal not false");
  chk_bool_range: assert property (
    one_st && op_code_i[0] <= OP_XOR |-> ##4 result_o <= TRUE_VALUE)
    else $error("logic result not zero or one");
  chk_div_zero: assert property (
    one_st && op_code_i[0] == OP_DIV && operand_b_i[0] == ZERO_VALUE
    |-> ##4 div_zero_o && result_o == FULL_SCALE) else $error("zero divisor result wrong");
  chk_add_clamp: assert property (
    one_st && op_code_i[0] == OP_ADD && 32'(operand_a_i) + 32'(operand_b_i[0]) > 32'(FULL_SCALE)
    |-> ##4 saturated_o && result_o == FULL_SCALE) else $error("sum not clamped");
  chk_sub_floor: assert property (
    one_st && op_code_i[0] == OP_SUB && operand_a_i < operand_b_i[0]
    |-> ##4 saturated_o && result_o == ZERO_VALUE) else $error("difference not floored");
  chk_pass_a: assert property (
    valid_i && b_used_i == 4'h0
    |-> ##4 result_o == $past(operand_a_i, 4) && !div_zero_o && !saturated_o)
    else $error("operand a not forwarded");
endmodule

bind math_block_operator_unit math_block_operator_unit_checker u_math_block_operator_unit_checker (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .valid_i(valid_i), .operand_a_i(operand_a_i),
  .operand_b_i(operand_b_i), .op_code_i(op_code_i), .b_used_i(b_used_i), .result_o(result_o),
  .result_valid_o(result_valid_o), .div_zero_o(div_zero_o), .saturated_o(saturated_o));

// ### testbench/math_block_operator_unit_tb_top.sv
`timescale 1ns/100ps
module math_block_operator_unit_tb_top;
  import math_op_pkg::*;
  logic                              clock_i = 1'b0;
  logic                              reset_n_i = 1'b0;
  logic                              valid_i = 1'b0;
  data_type                          a_level = 16'h0000;
  logic [NUM_STAGES-1:0][DATA_W-1:0] operand_b_i = '0;
  logic [NUM_STAGES-1:0][OP_W-1:0]   op_code_i = '0;
  logic [NUM_STAGES-1:0]             b_used_i = '0;
  data_type                          operand_a_i;
  data_type                          result_o;
  logic                              result_valid_o;
  logic                              div_zero_o;
  logic                              saturated_o;
  int                                error_cnt = 0;
  int                                tests_run = 0;
  int                                cycles = 0;
  localparam data_type av[5] = '{16'h0000, 16'h0001, 16'h1388, 16'h2328, 16'h2710};
  localparam data_type bv[4] = '{16'h0000, 16'h0001, 16'h1388, 16'h2328};

  always #2.5 clock_i = ~clock_i;

  operand_source u_operand_source (
    .valid_i(valid_i), .level_i(a_level), .operand_a_o(operand_a_i));
  math_block_operator_unit u_math_block_operator_unit (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .valid_i(valid_i), .operand_a_i(operand_a_i),
    .operand_b_i(operand_b_i), .op_code_i(op_code_i), .b_used_i(b_used_i),
    .result_o(result_o), .result_valid_o(result_valid_o), .div_zero_o(div_zero_o),
    .saturated_o(saturated_o));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [17:0] ref_op(data_type a, data_type b, op_type op);
    int   x;
    logic sat;
    case (op)
      OP_EQ:  x = a == b;
      OP_NE:  x = a != b;
      OP_GT:  x = a > b;
      OP_GE:  x = a >= b;
      OP_LT:  x = a < b;
      OP_LE:  x = a <= b;
      OP_OR:  x = (a >= TRUE_THRESHOLD) || (b >= TRUE_THRESHOLD);
      OP_AND: x = (a >= TRUE_THRESHOLD) && (b >= TRUE_THRESHOLD);
      OP_XOR: x = (a >= TRUE_THRESHOLD) != (b >= TRUE_THRESHOLD);
      OP_ADD: x = a + b;
      OP_SUB: x = a - b;
      OP_MUL: x = a * b / 10000;
      OP_DIV: x = (b == 0) ? 10000 : a * 10000 / b;
      OP_MIN: x = (a < b) ? a : b;
      OP_MAX: x = (a > b) ? a : b;
      default: x = a;
    endcase
    sat = op inside {[OP_ADD:OP_DIV]} && (x < 0 || x > 10000);
    if (sat) x = (x < 0) ? 0 : 10000;
    return {op == OP_DIV && b == 0, sat, 16'(x)};
  endfunction

  function automatic logic [17:0] chain(data_type a, logic [63:0] b, logic [15:0] ops,
                                        logic [3:0] used);
    logic [17:0] r;
    logic [17:0] t;
    r = {2'b00, a};
    for (int k = 0; k < 4; k++) begin
      if (used[k]) begin
        t = ref_op(r[15:0], b[16*k+:16], ops[4*k+:4]);
        r = {r[17:16] | t[17:16], t[15:0]};
      end
    end
    return r;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic send(data_type a, logic [63:0] b, logic [15:0] ops, logic [3:0] used);
    logic [17:0] e;
    e = chain(a, b, ops, used);
    @(posedge clock_i);
    valid_i <= 1'b1;
    a_level <= a;
    operand_b_i <= b;
    op_code_i <= ops;
    b_used_i <= used;
    @(posedge clock_i);
    valid_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    check(16'(result_valid_o), 16'h0001);
    check(result_o, e[15:0]);
    check({14'h0, div_zero_o, saturated_o}, {14'h0, e[17:16]});
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_compare;
    for (int op = 0; op < 9; op++)
      foreach (av[i]) foreach (bv[j])
        send(av[i], {48'h0, bv[j]}, {12'h0, 4'(op)}, 4'h1);
  endtask

  task automatic t_arith;
    for (int op = 9; op < 15; op++)
      foreach (av[i]) foreach (bv[j])
        send(av[i], {48'h0, bv[j]}, {12'h0, 4'(op)}, 4'h1);
  endtask

  task automatic t_cascade;
    send(16'h0bb8, {16'h0fa0, 16'h07d0, 16'h1388, 16'h2328}, {OP_ADD, OP_MUL, OP_SUB, OP_MAX},
         4'hf);
    send(16'h07d0, {16'h0001, 16'h0000, 16'h2328, 16'h0fa0}, {4'hf, OP_DIV, 4'hf, OP_ADD},
         4'hf);
    send(16'h1388, {16'h0fa0, 16'h0001, 16'h0001, 16'h0001}, {OP_SUB, OP_ADD, OP_ADD, OP_ADD},
         4'b1010);
    send(16'h4e20, 64'h0, 16'h0000, 4'h0);
  endtask

  task automatic t_reset;
    send(16'h07d0, {16'h0001, 16'h0000, 16'h2328, 16'h0fa0}, {4'hf, OP_DIV, 4'hf, OP_ADD},
         4'hf);
    @(posedge clock_i);
    reset_n_i <= 1'b0;
    #1;
    check(result_o, RESULT_RESET);
    check({13'h0, result_valid_o, div_zero_o, saturated_o}, 16'h0000);
    repeat (4) @(posedge clock_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
    check(result_o, RESULT_RESET);
    check({13'h0, result_valid_o, div_zero_o, saturated_o}, 16'h0000);
  endtask

  task automatic t_b2b;
    logic [17:0] e;
    for (int k = 0; k < 7; k++) begin
      @(posedge clock_i);
      valid_i <= k < 3;
      a_level <= 16'h03e8 * 16'(k);
      operand_b_i <= {48'h0, 16'h2328};
      op_code_i <= {12'h0, OP_ADD};
      b_used_i <= 4'h1;
      #1;
      if (k >= 4) begin
        e = chain(16'h03e8 * 16'(k - 4), {48'h0, 16'h2328}, {12'h0, OP_ADD}, 4'h1);
        check(16'(result_valid_o), 16'h0001);
        check(result_o, e[15:0]);
        check({14'h0, div_zero_o, saturated_o}, {14'h0, e[17:16]});
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      test_done();
    end
  end

  initial begin
    repeat (6) @(posedge clock_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    t_compare();
    t_arith();
    t_cascade();
    t_reset();
    t_b2b();
    test_done();
  end
endmodule

// ### testbench/operand_source.sv
`timescale 1ns/100ps
module operand_source
  import math_op_pkg::*;
(
  input  wire logic     valid_i,
  input  wire data_type level_i,
  output data_type      operand_a_o
);
  // between samples show the inverse, never a stale copy
  assign operand_a_o = valid_i ? level_i : ~level_i;
endmodule
